//--- rtl/pspc_profile.sv
// Speed profile generator: command pulses, ramps, stops, overrides.
// Assumes commands are one-cycle strobes and settings come from same-clock logic.
`timescale 1ns/10ps
`include "pspc_cfg.svh"
module pspc_profile (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Command strobe
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    // Settings
    input wire pspc_pkg::pspc_speed_s speed_i,
    input wire pspc_pkg::pspc_mode_s mode_i,
    input wire logic speed_write_i,
    // Motor pulse and status
    output logic pulse_o,
    output logic busy_o,
    output logic error_o,
    output logic [15:0] current_speed_o,
    output logic [31:0] remaining_pulses_o,
    output logic [15:0] eff_target_o,
    output logic [31:0] eff_slowdown_o
);
    import pspc_pkg::*;

    pspc_state_e state, next_state;
    logic [15:0] speed, next_speed;
    logic [15:0] goal, next_goal;
    logic [31:0] phase, next_phase;
    logic [31:0] remaining_pulses, next_remaining_pulses;
    logic [15:0] warm_left, next_warm_left;
    logic [31:0] step_cnt, next_step_cnt;
    logic [15:0] s_cnt, next_s_cnt;
    logic ramped, next_ramped;
    logic pulse, next_pulse;
    logic error, next_error;
    logic [15:0] eff_target, next_eff_target;
    logic [31:0] eff_slowdown, next_eff_slowdown;
    logic pend_ovr, next_pend_ovr;
    logic [15:0] ovr_goal, next_ovr_goal;
    logic sq_start;
    logic sq_busy;
    logic sq_busy_q;
    logic s_full;
    logic [23:0] sq_root;
    logic [47:0] radicand;
    logic [32:0] phase_sum;
    logic [31:0] step_len;
    logic [15:0] rate_used;
    logic tick_out;
    logic at_slowdown;

    // True for motion kinds that carry a target position
    function automatic logic kind_has_target(input logic [7:0] k);
        unique case (k)
            8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
            8'h56, 8'h61, 8'h64, 8'h65, 8'h66, 8'h67, 8'h69, 8'h6C, 8'h6D: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : kind_has_target

    // True for any of the four start codes
    function automatic logic is_start(input logic [7:0] c);
        return c == `PSPC_CMD_START_LOW_CONST || c == `PSPC_CMD_START_HIGH_CONST ||
               c == `PSPC_CMD_START_RAMP_HOLD || c == `PSPC_CMD_START_RAMP_FULL;
    endfunction : is_start

    // Linear limit squared; S-curve doubles the rate sum
    always_comb begin
        logic [47:0] num;
        logic [17:0] den;
        num = 48'((speed_i.speed_multiplier_setting + 48'h1) * `PSPC_LIMIT_SCALE
              * mode_i.feed_amount);
        den = 18'(speed_i.accel_rate_setting) + 18'(speed_i.decel_rate_setting) + 18'h2;
        if (mode_i.curve_shape_select) begin
            den = {den[16:0], 1'b0};
        end
        radicand = 48'(num / den) + 48'(speed_i.start_speed_value * speed_i.start_speed_value);
    end

    pspc_isqrt u_isqrt (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .start_i(sq_start),
        .radicand_i(radicand),
        .busy_o(sq_busy),
        .root_o(sq_root)
    );

    // Phase accumulator; carry out of bit 15 scaled by multiplier+1
    assign phase_sum = {1'b0, phase} + {17'h0, speed};
    assign tick_out = (state != PSPC_IDLE) && (state != PSPC_ERRS) && !sq_busy
                      && phase_sum[32:`PSPC_RATE_SHIFT] >
                         {5'h0, speed_i.speed_multiplier_setting};
    // Zero decel rate falls back on the accel rate
    assign rate_used = (state == PSPC_SLOW && speed_i.decel_rate_setting != 16'h0000) ?
                       speed_i.decel_rate_setting : speed_i.accel_rate_setting;
    // Linear step every (rate+1)*4 clocks; S-curve stretches ends
    // Zero section widths make the whole ramp S-shaped
    assign s_full = speed_i.accel_s_section == 16'h0000 && speed_i.decel_s_section == 16'h0000;
    assign step_len = 32'((rate_used + 32'h1) * `PSPC_RATE_STEP_CLOCKS)
                      + ((mode_i.curve_shape_select && (s_cnt != 16'h0000 || s_full)) ? 32'((rate_used
                      + 32'h1) * `PSPC_RATE_STEP_CLOCKS) : `PSPC_ZERO32);
    // Incremental ramped slowdown point
    assign at_slowdown = mode_i.incremental && ramped && remaining_pulses < eff_slowdown;
    // Lowering starts at a start command when limit check applies
    assign sq_start = cmd_valid_i && is_start(cmd_code_i) && state == PSPC_IDLE
                      && kind_has_target(mode_i.motion_kind_code) && !mode_i.top_speed_autofix;

    // Main sequencing
    always_comb begin
        next_state = state;
        next_speed = speed;
        next_goal = goal;
        next_phase = phase;
        next_remaining_pulses = remaining_pulses;
        next_warm_left = warm_left;
        next_step_cnt = step_cnt;
        next_s_cnt = s_cnt;
        next_ramped = ramped;
        next_pulse = 1'b0;
        next_error = error;
        next_eff_target = eff_target;
        next_eff_slowdown = eff_slowdown;
        next_pend_ovr = pend_ovr;
        next_ovr_goal = ovr_goal;
        unique case (state)
            PSPC_IDLE: begin
                next_phase = `PSPC_ZERO32;
                if (cmd_valid_i && is_start(cmd_code_i)) begin
                    next_error = 1'b0;
                    next_remaining_pulses = mode_i.feed_amount;
                    next_eff_target = speed_i.target_speed_value;
                    next_eff_slowdown = mode_i.slowdown_point_value + mode_i.slowdown_offset;
                    next_speed = speed_i.start_speed_value;
                    next_goal = speed_i.target_speed_value;
                    next_ramped = cmd_code_i == `PSPC_CMD_START_RAMP_HOLD ||
                                  cmd_code_i == `PSPC_CMD_START_RAMP_FULL;
                    next_warm_left = mode_i.warmup_pulse_count;
                    next_step_cnt = `PSPC_ZERO32;
                    next_s_cnt = speed_i.accel_s_section;
                    next_pend_ovr = 1'b0;
                    if (cmd_code_i == `PSPC_CMD_START_HIGH_CONST) begin
                        next_speed = speed_i.target_speed_value;
                    end
                    if (cmd_code_i == `PSPC_CMD_START_LOW_CONST) begin
                        next_goal = speed_i.start_speed_value;
                    end
                    // Ramp-hold without warm-up starts straight at target speed
                    if (cmd_code_i == `PSPC_CMD_START_RAMP_HOLD &&
                        mode_i.warmup_pulse_count == 16'h0000) begin
                        next_speed = speed_i.target_speed_value;
                    end
                    next_state = (next_ramped && next_warm_left != 16'h0000) ?
                                 PSPC_WARM : PSPC_RUN;
                    if (mode_i.incremental && mode_i.feed_amount == `PSPC_ZERO32) begin
                        next_state = PSPC_IDLE;
                    end
                end
            end
            PSPC_ERRS: begin
                // Stays stopped until the next start clears the flag
                next_state = PSPC_IDLE;
            end
            default: begin
                // Hold the phase and pulses while the root is computed
                if (sq_busy) begin
                    next_phase = phase;
                end else if (tick_out) begin
                    next_phase = {16'h0000, phase_sum[15:0]};
                    next_pulse = 1'b1;
                    if (mode_i.incremental) begin
                        next_remaining_pulses = remaining_pulses - 32'h1;
                    end
                    if (state == PSPC_WARM) begin
                        next_warm_left = warm_left - 16'h0001;
                        if (warm_left == 16'h0001) begin
                            next_state = PSPC_RUN;
                        end
                    end
                    // Override takes effect from the pulse after the write
                    if (pend_ovr) begin
                        next_pend_ovr = 1'b0;
                        next_goal = ovr_goal;
                        next_eff_target = ovr_goal;
                        if (!ramped) begin
                            next_speed = ovr_goal;
                        end
                    end
                end else begin
                    next_phase = phase_sum[31:0];
                end
                // Ramp stepping toward the goal
                if (!sq_busy && ramped && state != PSPC_WARM) begin
                    next_step_cnt = step_cnt + 32'h1;
                    if (step_cnt + 32'h1 >= step_len) begin
                        next_step_cnt = `PSPC_ZERO32;
                        if (s_cnt != 16'h0000) begin
                            next_s_cnt = s_cnt - 16'h0001;
                        end
                        if (speed < goal) begin
                            next_speed = speed + 16'h0001;
                        end else if (speed > goal) begin
                            next_speed = speed - 16'h0001;
                        end
                    end
                end
                // Incremental slowdown
                if (at_slowdown && state == PSPC_RUN && goal != speed_i.start_speed_value) begin
                    next_goal = speed_i.start_speed_value;
                    next_s_cnt = speed_i.decel_s_section;
                end
                // Slow-halt reaching start speed ends the move
                if (state == PSPC_SLOW && speed <= speed_i.start_speed_value) begin
                    next_state = PSPC_IDLE;
                end
                // Slow-halt command
                if (cmd_valid_i && cmd_code_i == `PSPC_CMD_SLOW_HALT) begin
                    if (speed <= speed_i.start_speed_value) begin
                        next_state = PSPC_IDLE;
                    end else begin
                        next_state = PSPC_SLOW;
                        next_ramped = 1'b1;
                        next_goal = speed_i.start_speed_value;
                        next_s_cnt = speed_i.decel_s_section;
                    end
                end
                // Halt, or incremental count exhausted, stops at once
                if ((cmd_valid_i && cmd_code_i == `PSPC_CMD_HALT) ||
                    (mode_i.incremental && next_remaining_pulses == `PSPC_ZERO32)) begin
                    next_state = PSPC_IDLE;
                end
            end
        endcase
        // Live rewrites are overrides in target kinds only
        // Placed after the pulse logic so a new write wins over the pulse's clear
        if (speed_write_i && state != PSPC_IDLE && kind_has_target(mode_i.motion_kind_code)) begin
            next_pend_ovr = 1'b1;
            next_ovr_goal = speed_i.target_speed_value;
        end
        // Root ready: lower target, correct auto slowdown, or flag asymmetry
        if (!sq_busy && sq_busy_q && ramped && sq_root[15:0] < eff_target
            && sq_root[23:16] == 8'h00) begin
            if (speed_i.accel_rate_setting != speed_i.decel_rate_setting &&
                speed_i.decel_rate_setting != 16'h0000 ||
                speed_i.accel_s_section != speed_i.decel_s_section) begin
                next_error = 1'b1;
                next_state = PSPC_ERRS;
            end else begin
                next_eff_target = sq_root[15:0];
                next_goal = sq_root[15:0];
                if (!mode_i.slowdown_manual_select) begin
                    // Half the feed is the symmetric turn point
                    next_eff_slowdown = {1'b0, mode_i.feed_amount[31:1]} + mode_i.slowdown_offset;
                end
            end
        end
    end

    // Root completion edge detect; same clock so no synchroniser
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sq_busy_q <= 1'b0;
        end else begin
            sq_busy_q <= sq_busy;
        end
    end

    // Register all profile state; a stop in a pulse cycle still shows that pulse in the first idle cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state <= PSPC_IDLE;
            speed <= 16'h0000;
            goal <= 16'h0000;
            phase <= 32'h00000000;
            remaining_pulses <= 32'h00000000;
            warm_left <= 16'h0000;
            step_cnt <= 32'h00000000;
            s_cnt <= 16'h0000;
            ramped <= 1'b0;
            pulse <= 1'b0;
            error <= 1'b0;
            eff_target <= 16'h0000;
            eff_slowdown <= 32'h00000000;
            pend_ovr <= 1'b0;
            ovr_goal <= 16'h0000;
        end else begin
            state <= next_state;
            speed <= next_speed;
            goal <= next_goal;
            phase <= next_phase;
            remaining_pulses <= next_remaining_pulses;
            warm_left <= next_warm_left;
            step_cnt <= next_step_cnt;
            s_cnt <= next_s_cnt;
            ramped <= next_ramped;
            pulse <= next_pulse;
            error <= next_error;
            eff_target <= next_eff_target;
            eff_slowdown <= next_eff_slowdown;
            pend_ovr <= next_pend_ovr;
            ovr_goal <= next_ovr_goal;
        end
    end

    assign pulse_o = pulse;
    assign busy_o = state != PSPC_IDLE && state != PSPC_ERRS;
    assign error_o = error;
    assign current_speed_o = speed;
    assign remaining_pulses_o = remaining_pulses;
    assign eff_target_o = eff_target;
    assign eff_slowdown_o = eff_slowdown;
endmodule : pspc_profile

//--- include/pspc_cfg.svh
// Constants for the pulse speed profile controller.
// Assumes a single 10 MHz clock and a host that drives plain command and setting ports.
`ifndef PSPC_CFG_SVH
`define PSPC_CFG_SVH
`define PSPC_CMD_START_LOW_CONST 8'h50
`define PSPC_CMD_START_HIGH_CONST 8'h51
`define PSPC_CMD_START_RAMP_HOLD 8'h52
`define PSPC_CMD_START_RAMP_FULL 8'h53
`define PSPC_CMD_HALT 8'h49
`define PSPC_CMD_SLOW_HALT 8'h4A
`define PSPC_RATE_SHIFT 16
`define PSPC_RATE_STEP_CLOCKS 14'h0004
`define PSPC_LIMIT_SCALE 48'h000000008000
`define PSPC_S_FALLBACK_FACTOR 32'h00000008
`define PSPC_ZERO32 32'h00000000
`endif

//--- include/pspc_pkg.sv
// Types shared by the pulse speed profile controller.
// Assumes pspc_cfg.svh is compiled alongside.
package pspc_pkg;
    typedef enum logic [4:0] {
        PSPC_IDLE = 5'h01,
        PSPC_WARM = 5'h02,
        PSPC_RUN = 5'h04,
        PSPC_SLOW = 5'h08,
        PSPC_ERRS = 5'h10
    } pspc_state_e;

    typedef struct packed {
        logic [15:0] start_speed_value;
        logic [15:0] target_speed_value;
        logic [11:0] speed_multiplier_setting;
        logic [15:0] accel_rate_setting;
        logic [15:0] decel_rate_setting;
        logic [15:0] accel_s_section;
        logic [15:0] decel_s_section;
    } pspc_speed_s;

    typedef struct packed {
        logic [7:0] motion_kind_code;
        logic incremental;
        logic top_speed_autofix;
        logic slowdown_manual_select;
        logic curve_shape_select;
        logic [31:0] feed_amount;
        logic [31:0] slowdown_point_value;
        logic [31:0] slowdown_offset;
        logic [15:0] warmup_pulse_count;
    } pspc_mode_s;
endpackage : pspc_pkg

//--- rtl/pspc_isqrt.sv
// Sequential integer square root, one result bit per clock.
// Assumes operand held stable while busy.
`timescale 1ns/10ps
module pspc_isqrt (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Request
    input wire logic start_i,
    input wire logic [47:0] radicand_i,
    // Result
    output logic busy_o,
    output logic [23:0] root_o
);
    logic [47:0] rem, next_rem;
    logic [23:0] root, next_root;
    logic [4:0] bitn, next_bitn;
    logic busy, next_busy;
    logic [23:0] trial;

    // Restoring method: try each bit from the top down
    always_comb begin
        trial = root | (24'h000001 << bitn);
        next_rem = rem;
        next_root = root;
        next_bitn = bitn;
        next_busy = busy;
        if (start_i) begin
            next_rem = radicand_i;
            next_root = 24'h000000;
            next_bitn = 5'h17;
            next_busy = 1'b1;
        end else if (busy) begin
            if ({24'h000000, trial} * {24'h000000, trial} <= rem) begin
                next_root = trial;
            end
            if (bitn == 5'h00) begin
                next_busy = 1'b0;
            end else begin
                next_bitn = bitn - 5'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rem <= 48'h000000000000;
            root <= 24'h000000;
            bitn <= 5'h00;
            busy <= 1'b0;
        end else begin
            rem <= next_rem;
            root <= next_root;
            bitn <= next_bitn;
            busy <= next_busy;
        end
    end

    assign busy_o = busy;
    assign root_o = root;
endmodule : pspc_isqrt

//--- test/pspc_profile_monitor.sv
// Port-level assertions for the pulse speed profile generator.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/10ps
`include "pspc_cfg.svh"
module pspc_profile_monitor (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Command and settings
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire pspc_pkg::pspc_speed_s speed_i,
    input wire pspc_pkg::pspc_mode_s mode_i,
    input wire logic speed_write_i,
    // Outputs watched
    input wire logic pulse_o,
    input wire logic busy_o,
    input wire logic error_o,
    input wire logic [15:0] current_speed_o,
    input wire logic [31:0] remaining_pulses_o,
    input wire logic [15:0] eff_target_o,
    input wire logic [31:0] eff_slowdown_o
);
    import pspc_pkg::*;
    default clocking mon_clk @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);
    logic go_ok;
    // A start that the block must take: idle, and not an empty incremental move
    assign go_ok = cmd_valid_i && !busy_o && !(mode_i.incremental && mode_i.feed_amount == 32'h0);

    low_start_a: assert property (go_ok && cmd_code_i == `PSPC_CMD_START_LOW_CONST |=>
        busy_o && current_speed_o == $past(speed_i.start_speed_value))
        else $error("low start speed wrong");
    high_start_a: assert property (go_ok && cmd_code_i == `PSPC_CMD_START_HIGH_CONST |=>
        busy_o && current_speed_o == $past(speed_i.target_speed_value))
        else $error("high start speed wrong");
    ramp_start_a: assert property (go_ok && mode_i.top_speed_autofix &&
        (cmd_code_i == `PSPC_CMD_START_RAMP_FULL || (cmd_code_i == `PSPC_CMD_START_RAMP_HOLD
        && mode_i.warmup_pulse_count != 16'h0000)) |=> current_speed_o == $past(speed_i.start_speed_value))
        else $error("ramp start speed wrong");
    halt_now_a: assert property (busy_o && cmd_valid_i && cmd_code_i == `PSPC_CMD_HALT |=> !busy_o)
        else $error("halt did not stop");
    pulse_single_a: assert property (pulse_o |=> !pulse_o)
        else $error("pulse wider than one cycle");
    idle_quiet_a: assert property (!busy_o ##1 !busy_o |-> !pulse_o)
        else $error("pulse while idle");
    zero_stop_a: assert property (mode_i.incremental && remaining_pulses_o == 32'h0 &&
        $changed(remaining_pulses_o) |-> !busy_o)
        else $error("no stop at zero remaining");
    count_down_a: assert property (busy_o && $past(busy_o) && mode_i.incremental &&
        $changed(remaining_pulses_o) |-> remaining_pulses_o == $past(remaining_pulses_o) - 32'h1)
        else $error("remaining count step wrong");
    error_idle_a: assert property ($rose(error_o) |-> !busy_o)
        else $error("error raised while moving");

    // Main scenarios reached
    cover property (go_ok && cmd_code_i == `PSPC_CMD_START_LOW_CONST);
    cover property (busy_o && cmd_valid_i && cmd_code_i == `PSPC_CMD_SLOW_HALT);
    cover property ($rose(error_o));
    cover property (busy_o && speed_write_i);
endmodule : pspc_profile_monitor

bind pspc_profile pspc_profile_monitor pspc_profile_monitor_inst (.clock_i(clock_i),
    .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .speed_i(speed_i),
    .mode_i(mode_i), .speed_write_i(speed_write_i), .pulse_o(pulse_o), .busy_o(busy_o),
    .error_o(error_o), .current_speed_o(current_speed_o), .remaining_pulses_o(remaining_pulses_o),
    .eff_target_o(eff_target_o), .eff_slowdown_o(eff_slowdown_o));

//--- test/pspc_motor_model.sv
// Motor driver stand-in: counts command pulses and their spacing.
// Assumes pulses are one-cycle strobes on the shared clock.
`timescale 1ns/10ps
module pspc_motor_model (
    // Clock
    input wire logic clock_i,
    // Command pulse
    input wire logic pulse_i,
    // Observed motion
    output logic [31:0] count_o,
    output logic [31:0] gap_o
);
    logic [31:0] since = 32'h0;
    initial count_o = 32'h0;
    initial gap_o = 32'h0;
    // Spacing is edge to edge, so a gap of N means one step every N clocks
    always @(posedge clock_i) begin
        since <= since + 32'h1;
        if (pulse_i) begin
            count_o <= count_o + 32'h1;
            gap_o <= since + 32'h1;
            since <= 32'h0;
        end
    end
endmodule : pspc_motor_model

//--- test/pspc_profile_test.sv
// Self-checking bench for the pulse speed profile generator.
// Assumes the motor model and the bound monitor are compiled alongside.
`timescale 1ns/10ps
`include "pspc_cfg.svh"
module pspc_profile_test;
    import pspc_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [7:0] cmd_code_i = 8'h00;
    pspc_speed_s speed_i = '0;
    pspc_mode_s mode_i = '0;
    logic speed_write_i = 1'b0;
    logic pulse_o, busy_o, error_o;
    logic [15:0] current_speed_o, eff_target_o;
    logic [31:0] remaining_pulses_o, eff_slowdown_o, n_pulse, gap;
    int n_fail = 0;
    int n_tests = 0;

    // 10 MHz clock
    always #50 clock_i = ~clock_i;

    pspc_profile pspc_profile_inst (.clock_i(clock_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_code_i(cmd_code_i), .speed_i(speed_i), .mode_i(mode_i), .speed_write_i(speed_write_i),
        .pulse_o(pulse_o), .busy_o(busy_o), .error_o(error_o), .current_speed_o(current_speed_o),
        .remaining_pulses_o(remaining_pulses_o), .eff_target_o(eff_target_o),
        .eff_slowdown_o(eff_slowdown_o));
    pspc_motor_model pspc_motor_model_inst (.clock_i(clock_i), .pulse_i(pulse_o),
        .count_o(n_pulse), .gap_o(gap));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    task automatic cmd(input logic [7:0] c);
        cmd_valid_i = 1'b1;
        cmd_code_i = c;
        tick(1);
        cmd_valid_i = 1'b0;
    endtask : cmd

    task automatic pulses(input int n);
        logic [31:0] b;
        int k;
        b = n_pulse;
        k = 0;
        while (n_pulse - b < n && k < 20000) begin
            tick(1);
            k++;
        end
    endtask : pulses

    task automatic wait_speed(input logic [15:0] s);
        int k;
        k = 0;
        while (current_speed_o !== s && k < 1000) begin
            tick(1);
            k++;
        end
    endtask : wait_speed

    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < lim) begin
            tick(1);
            k++;
        end
        check("busy", 32'(busy_o), 32'h0);
    endtask : wait_idle

    // Own reference root, kept apart from the design's square-root unit
    function automatic logic [31:0] root(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0;
        while ((r + 32'h1) * (r + 32'h1) <= v) r++;
        return r;
    endfunction : root

    task automatic t_const();
        speed_i = '{16'h1000, 16'h2000, 12'h000, 16'h0, 16'h0, 16'h0, 16'h0};
        mode_i = '{8'h41, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0, 32'h0, 16'h0};
        cmd(`PSPC_CMD_START_LOW_CONST);
        check("speed", 32'(current_speed_o), 32'h1000);
        pulses(3);
        check("gap", gap, 32'h10);
        cmd(`PSPC_CMD_SLOW_HALT);
        check("busy", 32'(busy_o), 32'h0);
        speed_i.speed_multiplier_setting = 12'h001;
        tick(1);
        cmd(`PSPC_CMD_START_HIGH_CONST);
        check("speed", 32'(current_speed_o), 32'h2000);
        pulses(3);
        check("gap", gap, 32'h10);
        speed_i.target_speed_value = 16'h4000;
        speed_write_i = 1'b1;
        tick(1);
        speed_write_i = 1'b0;
        pulses(3);
        check("gap", gap, 32'h8);
        check("speed", 32'(current_speed_o), 32'h4000);
        cmd(`PSPC_CMD_HALT);
        check("busy", 32'(busy_o), 32'h0);
        $display("Test constant done");
    endtask : t_const

    // Incremental full ramp, linear then complete S-curve
    task automatic t_ramp();
        logic [31:0] b;
        int t;
        for (int c = 0; c < 2; c++) begin
            speed_i = '{16'h0400, 16'h0428, 12'h000, 16'h0, 16'h0, 16'h0, 16'h0};
            mode_i = '{8'h41, 1'b1, 1'b1, 1'b1, c[0], 32'h28, 32'hA, 32'h0, 16'h2};
            tick(1);
            b = n_pulse;
            cmd(`PSPC_CMD_START_RAMP_FULL);
            check("speed", 32'(current_speed_o), 32'h400);
            pulses(2);
            t = 0;
            while (current_speed_o !== 16'h0428 && t < 1000) begin
                tick(1);
                t++;
            end
            check("ramp", 32'(t >= 152 * (c + 1) && t <= 164 * (c + 1)), 32'h1);
            check("sdown", eff_slowdown_o, 32'hA);
            while (remaining_pulses_o >= 32'hA && t < 6000) begin
                tick(1);
                t++;
            end
            tick(40);
            check("decel", 32'(current_speed_o < 16'h0428), 32'h1);
            wait_idle(3000);
            tick(1); // The last pulse is counted one edge after the stop
            check("count", n_pulse - b, 32'h28);
            check("left", remaining_pulses_o, 32'h0);
        end
        $display("Test ramp done");
    endtask : t_ramp

    task automatic t_slow();
        mode_i.incremental = 1'b0;
        mode_i.curve_shape_select = 1'b0;
        mode_i.warmup_pulse_count = 16'h1;
        cmd(`PSPC_CMD_START_RAMP_HOLD);
        check("speed", 32'(current_speed_o), 32'h400);
        wait_speed(16'h0428);
        check("top", 32'(current_speed_o), 32'h428);
        speed_i.target_speed_value = 16'h0414;
        speed_write_i = 1'b1;
        tick(1);
        speed_write_i = 1'b0;
        pulses(1);
        check("ramping", 32'(current_speed_o > 16'h0414), 32'h1);
        wait_speed(16'h0414);
        check("new top", 32'(current_speed_o), 32'h414);
        cmd(`PSPC_CMD_SLOW_HALT);
        check("busy", 32'(busy_o), 32'h1);
        wait_idle(1000);
        cmd(`PSPC_CMD_START_RAMP_FULL);
        tick(2);
        cmd(`PSPC_CMD_HALT);
        check("busy", 32'(busy_o), 32'h0);
        $display("Test slow halt done");
    endtask : t_slow

    // Automatic top-speed lowering, symmetric then asymmetric rates
    task automatic t_lower();
        logic [31:0] r;
        r = root(32'h8000 * 32'h64 / 32'h2 + 32'h64 * 32'h64);
        for (int d = 0; d < 2; d++) begin
            speed_i = '{16'h0064, 16'h0FA0, 12'h000, 16'h0, 16'(d * 5), 16'h0, 16'h0};
            mode_i = '{8'h41, 1'b1, 1'b0, 1'b0, 1'b0, 32'h64, 32'h0, 32'h0, 16'h0};
            tick(1);
            cmd(`PSPC_CMD_START_RAMP_FULL);
            tick(40);
            check("error", 32'(error_o), 32'(d));
            if (d == 0) begin
                check("top", 32'(eff_target_o), r);
                check("sdown", eff_slowdown_o, 32'h32);
                cmd(`PSPC_CMD_HALT);
            end
        end
        $display("Test lowering done");
    endtask : t_lower

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence after four cycles of reset
    initial begin
        tick(4);
        rstn_i = 1'b1;
        t_const();
        t_ramp();
        t_slow();
        t_lower();
        finish_test();
    end

    // Watchdog: tests need about 6k cycles, allow 40k
    initial begin
        #4000000;
        n_fail++;
        finish_test();
    end
endmodule : pspc_profile_test
